// ===== logic/icg_pkg.sv
// constants, field layout and types shared by the internal clock generator
package icg_pkg;
   // clock and timing
   localparam int CLK_NS     = 50;
   localparam int REF_WU_NS  = 10000;
   localparam int LOOP_WU_NS = 20000;
   localparam int ACQ_NS     = 40000;
   // least times round up to whole cycles
   localparam int REF_WU_CYC  = (REF_WU_NS + CLK_NS - 1) / CLK_NS;
   localparam int LOOP_WU_CYC = (LOOP_WU_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACQ_CYC     = (ACQ_NS + CLK_NS - 1) / CLK_NS;
   localparam int TMR_W       = 11;
   localparam logic [TMR_W-1:0] REF_WU_C  = TMR_W'(REF_WU_CYC - 1);
   localparam logic [TMR_W-1:0] LOOP_WU_C = TMR_W'(LOOP_WU_CYC);
   localparam logic [TMR_W-1:0] ACQ_C     = TMR_W'(ACQ_CYC);
   localparam logic [TMR_W-1:0] TMR_ZERO  = 11'h000;
   // apb register map (byte addresses)
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_TRIM = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h008;
   // ctrl fields
   localparam int CTRL_SEL_BIT = 0;
   localparam int CTRL_LOWPWR_BIT = 1;
   localparam int CTRL_RSE_BIT = 2;
   localparam int CTRL_DIV_LSB = 4;
   localparam int DIV_W        = 2;
   localparam logic [DIV_W-1:0] DIV_RST = 2'h1;
   localparam logic [DIV_W-1:0] DIV_ONE = 2'h0;
   // trim fields
   localparam int TRIM_W        = 8;
   localparam int TRIM_FINE_BIT = 8;
   localparam logic [TRIM_W-1:0] TRIM_DEF = 8'h80;
   // status fields
   localparam int STAT_REF_RDY  = 0;
   localparam int STAT_LOCK     = 1;
   localparam int STAT_STOP     = 2;
   localparam int STAT_MODE_LSB = 4;
   // oscillator model
   localparam int PER_W = 10;
   localparam logic [PER_W-1:0] REF_BASE = 10'h040;
   localparam int LOOP_SHIFT = 2;
   localparam int DCNT_W     = 3;
   localparam logic [DCNT_W-1:0] DCNT_ZERO = 3'h0;
   localparam logic [DCNT_W-1:0] DCNT_ONE  = 3'h1;
   typedef enum logic [1:0] {
      loop_engaged_internal_mode,
      loop_bypassed_internal_mode,
      loop_bypassed_internal_lowpower_mode
   } icg_mode_e;
   typedef enum logic [1:0] {st_run, st_stop, st_ref_wake} icg_state_e;
endpackage

// ===== logic/icg_tick_if.sv
// carrier between the generator core and one period counter
`timescale 1ns/1ps
interface icg_tick_if;
   import icg_pkg::*;
   logic             run;
   logic [PER_W-1:0] period;
   logic             tick;
   modport gen (input run, input period, output tick);
   modport ctl (output run, output period, input tick);
endinterface

// ===== logic/icg_tick_gen.sv
// period counter that emits one-cycle ticks, modelling an oscillator
`timescale 1ns/1ps
module icg_tick_gen
   import icg_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic ce,
   icg_tick_if.gen   t
);
   logic [PER_W-1:0] cnt_q;
   logic             tick_q;

   // a stopped oscillator restarts a full period after run returns
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if (ce) begin
         if (!t.run) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
         end else if (cnt_q >= t.period - PER_W'(1)) begin
            cnt_q  <= '0;
            tick_q <= 1'b1;
         end else begin
            cnt_q  <= cnt_q + PER_W'(1);
            tick_q <= 1'b0;
         end
      end
   end

   assign t.tick = tick_q;
endmodule

// ===== logic/icg_core.sv
// internal clock generator: reference, loop, stop handling and bus divider
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module icg_core
   import icg_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire logic              ce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              stop_req,
   input  wire logic              wake_req,
   input  wire logic              lowvolt_detect_enable,
   input  wire logic              lowvolt_stop_enable,
   output logic                   internal_ref_clock_out,
   output logic                   clock_generator_output,
   output logic                   bus_clock_en,
   output logic                   ref_ready,
   output logic                   loop_locked
);
   localparam int REF_WIN  = REF_WU_CYC + 2;
   localparam int LOOP_WIN = LOOP_WU_CYC + 2;

   icg_state_e        state_q;
   logic              sel_bypass_q;
   logic              low_power_select_q;
   logic              ref_stop_enable_q;
   logic [DIV_W-1:0]  bus_divider_select_q;
   logic [TRIM_W-1:0] ref_trim_register_q = TRIM_DEF;
   logic              fine_ref_trim_bit_q = 1'b0;
   logic              ref_keep_q;
   logic [TMR_W-1:0]  ref_cnt_q;
   logic [TMR_W-1:0]  loop_cnt_q;
   logic              loop_act_q;
   logic [DCNT_W-1:0] div_cnt_q;
   logic              gen_tick_q;
   logic              bus_tick_q;
   logic              ref_tick_q;
   logic [31:0]       prdata_q;
   icg_mode_e         mode;
   logic              wr_en;
   logic              trim_wr;
   logic              ref_run;
   logic              loop_en;
   logic              loop_act;
   logic              warm_wake;
   logic              gen_src;
   logic [PER_W-1:0]  ref_period;

   icg_tick_if ref_if ();
   icg_tick_if loop_if ();

   // register index decode, used by the read mux and the write strobes
   function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
      case (a)
         ADDR_CTRL: reg_sel = 2'h1;
         ADDR_TRIM: reg_sel = 2'h2;
         ADDR_STAT: reg_sel = 2'h3;
         default:   reg_sel = 2'h0;
      endcase
   endfunction

   // low bits of the divide counter that must be zero for a bus tick
   function automatic logic [DCNT_W-1:0] div_mask(input logic [DIV_W-1:0] s);
      div_mask = (DCNT_ONE << s) - DCNT_ONE;
   endfunction

   // apb handshake: zero wait states, ce low stretches the access
   assign pready  = psel & penable & ce;
   assign pslverr = pready & (reg_sel(paddr) == 2'h0);
   assign wr_en   = pready & pwrite;
   assign trim_wr = wr_en & (reg_sel(paddr) == 2'h2);
   assign prdata  = prdata_q;

   // effective operating mode from the select and low power bits
   always_comb begin
      if (!sel_bypass_q) begin
         mode = loop_engaged_internal_mode;
      end else if (low_power_select_q) begin
         mode = loop_bypassed_internal_lowpower_mode;
      end else begin
         mode = loop_bypassed_internal_mode;
      end
   end

   // control register; divider resets to divide-by-2
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sel_bypass_q         <= 1'b0;
         low_power_select_q   <= 1'b0;
         ref_stop_enable_q    <= 1'b0;
         bus_divider_select_q <= DIV_RST;
      end else if (ce && wr_en && reg_sel(paddr) == 2'h1) begin
         sel_bypass_q         <= pwdata[CTRL_SEL_BIT];
         low_power_select_q   <= pwdata[CTRL_LOWPWR_BIT];
         ref_stop_enable_q    <= pwdata[CTRL_RSE_BIT];
         bus_divider_select_q <= pwdata[CTRL_DIV_LSB +: DIV_W];
      end
   end

   // trim survives every reset, so no reset branch here
   always_ff @(posedge mclk) begin
      if (ce && trim_wr) begin
         ref_trim_register_q <= pwdata[TRIM_W-1:0];
         fine_ref_trim_bit_q <= pwdata[TRIM_FINE_BIT];
      end
   end

   // read data captured in the setup cycle
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         prdata_q <= '0;
      end else if (ce && psel && !penable) begin
         prdata_q <= '0;
         case (reg_sel(paddr))
            2'h1: begin
               prdata_q[CTRL_SEL_BIT]              <= sel_bypass_q;
               prdata_q[CTRL_LOWPWR_BIT]           <= low_power_select_q;
               prdata_q[CTRL_RSE_BIT]              <= ref_stop_enable_q;
               prdata_q[CTRL_DIV_LSB +: DIV_W]     <= bus_divider_select_q;
            end
            2'h2: begin
               prdata_q[TRIM_W-1:0]                <= ref_trim_register_q;
               prdata_q[TRIM_FINE_BIT]             <= fine_ref_trim_bit_q;
            end
            2'h3: begin
               prdata_q[STAT_REF_RDY]              <= ref_ready;
               prdata_q[STAT_LOCK]                 <= loop_locked;
               prdata_q[STAT_STOP]                 <= (state_q == st_stop);
               prdata_q[STAT_MODE_LSB +: 2]        <= mode;
            end
            default: prdata_q <= '0;
         endcase
      end
   end

   // stop state machine; control bits are untouched so the mode resumes
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_q    <= st_run;
         ref_keep_q <= 1'b0;
         ref_cnt_q  <= TMR_ZERO;
      end else if (ce) begin
         case (state_q)
            st_run: begin
               if (stop_req) begin
                  state_q    <= st_stop;
                  // the reference only survives stop with the supply monitor held on
                  ref_keep_q <= ref_stop_enable_q & lowvolt_detect_enable & lowvolt_stop_enable;
               end
            end
            st_stop: begin
               if (wake_req && ref_keep_q) begin
                  state_q   <= st_run;
               end else if (wake_req) begin
                  state_q   <= st_ref_wake;
                  ref_cnt_q <= REF_WU_C;
               end
            end
            st_ref_wake: begin
               if (ref_cnt_q == TMR_ZERO) begin
                  state_q <= st_run;
               end else begin
                  ref_cnt_q <= ref_cnt_q - TMR_W'(1);
               end
            end
            default: state_q <= st_run;
         endcase
      end
   end

   // reference runs except in a cold stop or its wake-up window
   assign ref_run   = (state_q == st_run) | (state_q == st_stop & ref_keep_q);
   assign ref_ready = ref_run;
   // loop off in stop, and in bypass with low power set
   assign loop_en   = (state_q == st_run) & !(sel_bypass_q & low_power_select_q);
   // a warm stop keeps the loop's acquired state for its return
   assign loop_act  = loop_en | (state_q == st_stop & ref_keep_q);
   assign warm_wake = (state_q == st_stop) & wake_req & ref_keep_q;

   // loop settling timer; trim write wins over everything
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         loop_cnt_q <= ACQ_C;
         loop_act_q <= 1'b0;
      end else if (ce) begin
         loop_act_q <= loop_act;
         if (trim_wr) begin
            loop_cnt_q <= ACQ_C;
         end else if (warm_wake) begin
            loop_cnt_q <= LOOP_WU_C;
         end else if (loop_act && !loop_act_q) begin
            loop_cnt_q <= ACQ_C;
         end else if (loop_en && loop_cnt_q != TMR_ZERO) begin
            loop_cnt_q <= loop_cnt_q - TMR_W'(1);
         end
      end
   end

   assign loop_locked = loop_en & (loop_cnt_q == TMR_ZERO);

   // a larger trim gives a longer reference period
   assign ref_period     = REF_BASE + {1'b0, ref_trim_register_q, fine_ref_trim_bit_q};
   assign ref_if.run     = ref_run;
   assign ref_if.period  = ref_period;
   // the loop multiplies the trimmed reference, so trim reaches it too
   assign loop_if.run    = loop_en;
   assign loop_if.period = ref_period >> LOOP_SHIFT;

   icg_tick_gen u_ref (
      .mclk  (mclk),
      .rst_b (rst_b),
      .ce    (ce),
      .t     (ref_if)
   );

   icg_tick_gen u_loop (
      .mclk  (mclk),
      .rst_b (rst_b),
      .ce    (ce),
      .t     (loop_if)
   );

   // output source per mode; the generator output stops outside run, the reference output only in a cold stop and its wake-up window
   assign gen_src = sel_bypass_q ? ref_if.tick : loop_if.tick;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         gen_tick_q <= 1'b0;
         ref_tick_q <= 1'b0;
      end else if (ce) begin
         gen_tick_q <= gen_src & (state_q == st_run);
         ref_tick_q <= ref_if.tick & ref_run;
      end
   end

   // mask compare uses the live select, so a new divider acts at once
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         div_cnt_q  <= DCNT_ZERO;
         bus_tick_q <= 1'b0;
      end else if (ce) begin
         if (gen_tick_q) begin
            div_cnt_q <= div_cnt_q + DCNT_ONE;
         end
         bus_tick_q <= gen_tick_q & ((div_cnt_q & div_mask(bus_divider_select_q)) == DCNT_ZERO);
      end
   end

   assign internal_ref_clock_out = ref_tick_q;
   assign clock_generator_output = gen_tick_q;
   assign bus_clock_en           = bus_tick_q;

   // checks
   sequence s_cold_wake;
      state_q == st_stop && wake_req && !ref_keep_q && ce;
   endsequence

   sequence s_warm_wake;
      state_q == st_stop && wake_req && ref_keep_q && !trim_wr && ce;
   endsequence

   a_stop_gen_off: assert property (@(posedge mclk) disable iff (!rst_b)
      state_q == st_stop |=> !clock_generator_output)
      else $error("generator clock ran during stop");

   a_stop_ref_off: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_q == st_stop && !ref_keep_q) [*2] |-> !internal_ref_clock_out)
      else $error("reference ran in a cold stop");

   a_resume_mode: assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(state_q == st_stop) |-> mode == $past(mode))
      else $error("mode changed across stop");

   a_ref_wake: assert property (@(posedge mclk) disable iff (!rst_b || !ce)
      s_cold_wake |=> !ref_ready [*8] ##[1:REF_WIN] ref_ready)
      else $error("reference wake-up delay wrong");

   a_loop_wake: assert property (@(posedge mclk) disable iff (!rst_b || !ce)
      s_warm_wake ##1 loop_en |-> !loop_locked [*8] ##[1:LOOP_WIN] loop_locked)
      else $error("loop wake-up delay wrong");

   a_trim_unlock: assert property (@(posedge mclk) disable iff (!rst_b)
      trim_wr && ce |=> loop_cnt_q == ACQ_C && !loop_locked)
      else $error("trim write did not restart acquisition");

   a_div_now: assert property (@(posedge mclk) disable iff (!rst_b)
      ce && gen_tick_q && bus_divider_select_q == DIV_ONE |=> bus_clock_en)
      else $error("divide-by-1 missed a bus tick");

   a_lowpwr_loop_off: assert property (@(posedge mclk) disable iff (!rst_b)
      sel_bypass_q && low_power_select_q |-> !loop_if.run && !loop_locked)
      else $error("loop enabled in low power bypass");

   a_trim_period: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(fine_ref_trim_bit_q) && $stable(ref_trim_register_q) |-> ref_period == $past(ref_period) + PER_W'(1))
      else $error("trim did not lengthen the period");

   a_trim_keep: assert property (@(posedge mclk)
      !rst_b |=> $stable(ref_trim_register_q) && $stable(fine_ref_trim_bit_q))
      else $error("reset disturbed the trim");

   a_div_reset: assert property (@(posedge mclk)
      !rst_b |=> bus_divider_select_q == DIV_RST)
      else $error("divider not reset to divide-by-2");

   a_bypass_src: assert property (@(posedge mclk) disable iff (!rst_b)
      ce && sel_bypass_q && ref_if.tick && state_q == st_run |=> clock_generator_output)
      else $error("bypass output not from trimmed reference");
endmodule

// ===== bench/icg_power_model.sv
// power-side partner: lowvolt enables plus stop and wake requests
`timescale 1ns/1ps
module icg_power_model (
   input  wire logic mclk,
   output logic      stop_req,
   output logic      wake_req,
   output logic      lowvolt_detect_enable,
   output logic      lowvolt_stop_enable
);
   // quiet at time zero, no request pending
   initial begin
      stop_req = 1'b0;
      wake_req = 1'b0;
      lowvolt_detect_enable = 1'b0;
      lowvolt_stop_enable = 1'b0;
   end

   // enables settle one cycle before stop so entry samples them
   task go_stop(input logic keep);
      begin
         @(posedge mclk);
         lowvolt_detect_enable <= keep;
         lowvolt_stop_enable <= keep;
         @(posedge mclk);
         stop_req <= 1'b1;
         @(posedge mclk);
         stop_req <= 1'b0;
      end
   endtask

   // one-cycle interrupt that ends stop
   task go_wake;
      begin
         @(posedge mclk);
         wake_req <= 1'b1;
         @(posedge mclk);
         wake_req <= 1'b0;
      end
   endtask
endmodule

// ===== bench/internal_clock_source_modes_test.sv
// self-checking bench for the internal clock generator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module internal_clock_source_modes_test;
   import icg_pkg::*;
   typedef struct {logic [31:0] ctrl; logic [31:0] trim; logic [1:0] mode;} icg_row_s;
   localparam int LIMIT = 60000;
   logic              mclk;
   logic              rst_b;
   logic              ce;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              stop_req;
   logic              wake_req;
   logic              lv_det;
   logic              lv_stop;
   logic              ref_out;
   logic              gen_out;
   logic              bus_out;
   logic              ref_ready;
   logic              loop_locked;
   logic [31:0]       rd;
   logic              er;
   int                n_mismatch = 0;
   int                check_count = 0;
   int                cycles = 0;
   int                n, p, nr, ng, nb, pr, pg, pb;
   // ctrl, trim word, expected mode; covers every divider and mode
   icg_row_s rows [5] = '{'{32'h01, 32'h000, 2'h1}, '{32'h03, 32'h100, 2'h2},
      '{32'h21, 32'h001, 2'h1}, '{32'h10, 32'h002, 2'h0}, '{32'h30, 32'h000, 2'h0}};

   icg_core dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stop_req(stop_req), .wake_req(wake_req), .lowvolt_detect_enable(lv_det),
      .lowvolt_stop_enable(lv_stop), .internal_ref_clock_out(ref_out), .clock_generator_output(gen_out),
      .bus_clock_en(bus_out), .ref_ready(ref_ready), .loop_locked(loop_locked));

   icg_power_model partner (.mclk(mclk), .stop_req(stop_req), .wake_req(wake_req),
      .lowvolt_detect_enable(lv_det), .lowvolt_stop_enable(lv_stop));

   // 20 MHz clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task complete_run;
      begin
         if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   // hang guard, well above the expected run length
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_mismatch++;
         complete_run();
      end
   end

   // apb master: holds the request until pready is seen high
   task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      begin
         @(posedge mclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge mclk);
         penable <= 1'b1;
         // only the hang guard ends a wait that never sees pready
         do begin
            @(posedge mclk);
         end while (pready !== 1'b1);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   function logic pulse(input int w);
      return (w == 0) ? ref_out : (w == 1) ? gen_out : bus_out;
   endfunction

   // interval between two pulses; the first pulse only aligns
   task meas(input int w, output int q);
      int k;
      begin
         k = 0;
         do begin @(posedge mclk); k++; end while (pulse(w) !== 1'b1 && k < 5000);
         q = 0;
         do begin @(posedge mclk); q++; end while (pulse(w) !== 1'b1 && q < 5000);
      end
   endtask

   task count_pulses(input int cyc);
      int k;
      begin
         nr = 0;
         ng = 0;
         nb = 0;
         for (k = 0; k < cyc; k++) begin
            @(posedge mclk);
            nr += int'(ref_out === 1'b1);
            ng += int'(gen_out === 1'b1);
            nb += int'(bus_out === 1'b1);
         end
      end
   endtask

   task wait_lock(output int q);
      begin
         q = 0;
         do begin @(posedge mclk); q++; end while (loop_locked !== 1'b1 && q < 3000);
      end
   endtask

   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0);
      `CHK("ctrl after reset", 32'h10, rd)
      apb(1'b0, ADDR_TRIM, 32'h0);
      `CHK("trim power-up", 32'h80, rd)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("unmapped error", 1'b1, er)
      `CHK("unmapped data", 32'h0, rd)
      // table of modes, trims and dividers; trim always precedes divide-by-1
      foreach (rows[i]) begin
         apb(1'b1, ADDR_TRIM, rows[i].trim);
         apb(1'b1, ADDR_CTRL, rows[i].ctrl);
         pr = int'(REF_BASE) + int'({rows[i].trim[7:0], rows[i].trim[8]});
         pg = (rows[i].mode == 2'h0) ? (pr >> LOOP_SHIFT) : pr;
         pb = pg << rows[i].ctrl[5:4];
         if (rows[i].mode != 2'h2) begin
            wait_lock(n);
            `CHK("acquire cycles", 1'b1, (n >= 795 && n <= 805))
         end
         apb(1'b0, ADDR_STAT, 32'h0);
         `CHK("mode field", rows[i].mode, rd[5:4])
         `CHK("loop lock", (rows[i].mode != 2'h2), rd[1])
         meas(0, p);
         `CHK("ref period", pr, p)
         meas(1, p);
         `CHK("output period", pg, p)
         meas(2, p);
         `CHK("bus period", pb, p)
      end
      // warm stop: reference kept, loop needs its wake delay
      apb(1'b1, ADDR_TRIM, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h04);
      wait_lock(n);
      partner.go_stop(1'b1);
      repeat (3) @(posedge mclk);
      count_pulses(300);
      `CHK("gen in stop", 0, ng)
      `CHK("bus in stop", 0, nb)
      `CHK("ref kept", 1'b1, (nr >= 4))
      apb(1'b0, ADDR_STAT, 32'h0);
      `CHK("stop flag", 1'b1, rd[2])
      partner.go_wake();
      @(posedge mclk);
      `CHK("lock after wake", 1'b0, loop_locked)
      `CHK("ref ready warm", 1'b1, ref_ready)
      wait_lock(n);
      `CHK("loop wake cycles", 1'b1, (n >= 385 && n <= 405))
      apb(1'b0, ADDR_STAT, 32'h0);
      `CHK("mode kept warm", 2'h0, rd[5:4])
      // cold stop: reference halts and needs its own wake delay
      apb(1'b1, ADDR_CTRL, 32'h01);
      partner.go_stop(1'b0);
      repeat (3) @(posedge mclk);
      count_pulses(300);
      `CHK("ref halted", 0, nr)
      `CHK("gen halted", 0, ng)
      partner.go_wake();
      n = 0;
      for (int k = 0; k < 1000; k++) begin
         @(posedge mclk);
         if (ref_ready === 1'b0)
            n++;
         else if (n > 0)
            break;
      end
      `CHK("ref wake cycles", 200, n)
      apb(1'b0, ADDR_STAT, 32'h0);
      `CHK("mode kept cold", 2'h1, rd[5:4])
      meas(1, p);
      `CHK("bypass period back", 64, p)
      // ce low freezes the acquire timer, so lock slips by the frozen cycles
      apb(1'b1, ADDR_TRIM, 32'h0);
      ce <= 1'b0;
      repeat (100) @(posedge mclk);
      ce <= 1'b1;
      wait_lock(n);
      `CHK("frozen acquire", 1'b1, (n >= 795 && n <= 805))
      // trim survives a reset, divider does not
      apb(1'b1, ADDR_TRIM, 32'h105);
      apb(1'b1, ADDR_CTRL, 32'h37);
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      apb(1'b0, ADDR_CTRL, 32'h0);
      `CHK("ctrl after rerun", 32'h10, rd)
      apb(1'b0, ADDR_TRIM, 32'h0);
      `CHK("trim kept", 32'h105, rd)
      complete_run();
   end
endmodule
